/* File: common/ufml_pkg.sv */
// Constants for the channel mode-register and FIFO level logic.
// Assumes an Avalon-MM host with 32-bit data and byte addresses.
package ufml_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_CMD  = 5'h04;
  localparam logic [4:0] OFS_STAT = 5'h08;
  localparam logic [4:0] OFS_ISTS = 5'h0c;
  localparam logic [4:0] OFS_IMSK = 5'h10;

  // Field positions in channel_mode_zero / channel_mode_one
  localparam int MR0_WDOG_BIT  = 7;
  localparam int MR0_RXUP_BIT  = 6;
  localparam int MR0_TXTH_LSB  = 4;
  localparam int MR0_DEPTH_BIT = 3;
  localparam int MR1_RXLO_BIT  = 6;

  // Baud-rate group codes
  localparam logic [2:0] BAUD_NORMAL = 3'h0;
  localparam logic [2:0] BAUD_EXT1   = 3'h1;
  localparam logic [2:0] BAUD_EXT2   = 3'h4;

  // Command register fields
  localparam int         CMD_CODE_LSB   = 4;
  localparam logic [3:0] CMD_PTR_MR1    = 4'h1;
  localparam logic [3:0] CMD_PTR_MR0    = 4'hb;
  localparam int         CMD_RX_EN_BIT  = 0;
  localparam int         CMD_RX_DIS_BIT = 1;
  localparam int         CMD_TX_EN_BIT  = 2;
  localparam int         CMD_TX_DIS_BIT = 3;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [2:0] IRQ_RST  = 3'h0;

  // FIFO depths, receive fill levels and transmit free levels, indexed by threshold code
  localparam logic [4:0] DEPTH_SMALL = 5'h08;
  localparam logic [4:0] DEPTH_LARGE = 5'h10;
  localparam logic [4:0] RX_LVL_SMALL [0:3] = '{5'h01, 5'h03, 5'h06, 5'h08};
  localparam logic [4:0] RX_LVL_LARGE [0:3] = '{5'h01, 5'h08, 5'h0c, 5'h10};
  localparam logic [4:0] TX_LVL_SMALL [0:3] = '{5'h08, 5'h04, 5'h06, 5'h01};
  localparam logic [4:0] TX_LVL_LARGE [0:3] = '{5'h10, 5'h08, 5'h0c, 5'h01};

  // Receiver idle watchdog, in receiver bit times
  localparam logic [6:0] WDOG_BIT_TIMES = 7'h40;

  // Interrupt status bits
  localparam int IRQ_W    = 3;
  localparam int IRQ_TX   = 0;
  localparam int IRQ_RX   = 1;
  localparam int IRQ_WDOG = 2;

  typedef enum logic [2:0] {
    PTR_MR0 = 3'b001,
    PTR_MR1 = 3'b010,
    PTR_MR2 = 3'b100
  } ufml_ptr_e;

endpackage

/* File: common/ufml_lvl_if.sv */
// Count (bytes held or positions free), threshold code and result between the top and a comparator.
// Assumes the top drives count, code and deep combinationally.
`timescale 1ns/1ns
interface ufml_lvl_if #(parameter int CNT_W = 5);
  logic [CNT_W-1:0] count;
  logic [1:0]       code;
  logic             deep;
  logic             hit;
  modport cmp  (input count, input code, input deep, output hit);
  modport user (output count, output code, output deep, input hit);
endinterface

/* File: verilog/ufml_level_cmp.sv */
// Fill-level comparator for one direction of the channel FIFOs.
// Assumes count is bytes held (receive) or positions free (transmit).
`timescale 1ns/1ns
module ufml_level_cmp
  import ufml_pkg::*;
#(
  parameter bit IS_TX = 1'b0
)
(
  ufml_lvl_if.cmp lv
);
  wire [4:0] lvl_small = IS_TX ? TX_LVL_SMALL[lv.code] : RX_LVL_SMALL[lv.code];
  wire [4:0] lvl_large = IS_TX ? TX_LVL_LARGE[lv.code] : RX_LVL_LARGE[lv.code];
  wire [4:0] lvl       = lv.deep ? lvl_large : lvl_small;

  // Compared every clock so a request drops as soon as the level is lost
  assign lv.hit = ({{($bits(lv.count)){1'b0}}, 5'h00} | lv.count) >= lvl;
endmodule

/* File: verilog/ufml_mode_cfg.sv */
// Channel mode registers, FIFO interrupt levels, idle watchdog, irq.
// Assumes FIFO counts and access pulses come from the channel FIFOs
// on the same clock, and an Avalon-MM master with waitrequest.
//
// How it works
// - Mode-zero bits 5:4 pick transmit threshold
// - Empty queue after reset requests once enabled
// - Code 00 requests only when fully empty
// - Mode-zero bit 3 selects 8 or 16
// - Baud group codes 000, 001, 100 only
// - Small receive levels 1, 3, 6, 8
// - Large receive levels 1, 8, 12, 16
// - Small transmit free levels 8, 4, 6, 1
// - Large transmit free levels 16, 8, 12, 1
// - Receive code from mode-zero and mode-one bit 6
// - Threshold change applies after FIFO access
// - Pointer to mode-one by reset/command, then two
// - Idle watchdog raises receive after 64 bits
`timescale 1ns/1ns
module ufml_mode_cfg
  import ufml_pkg::*;
#(
  parameter int CNT_W = 5
)
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [4:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic [CNT_W-1:0] rx_count,
  input  wire logic [CNT_W-1:0] tx_count,
  input  wire logic             rx_fifo_access,
  input  wire logic             tx_fifo_access,
  input  wire logic             rx_bit_tick,
  output logic                  queue_depth_select,
  output logic      [2:0]       baud_group,
  output logic                  rx_idle_timer_enable,
  output logic      [7:0]       mode_one,
  output logic      [7:0]       mode_two,
  output logic                  rx_enable,
  output logic                  tx_enable,
  output logic                  rx_irq_req,
  output logic                  tx_irq_req,
  output logic                  irq
);

  if (CNT_W < 5)
  begin : g_bad_width
    $error("ufml_mode_cfg: CNT_W must hold a count of 16");
  end

  ufml_ptr_e        ptr_q;
  ufml_ptr_e        ptr_d;
  logic [7:0]       mode_zero_q;
  logic [7:0]       mode_one_q;
  logic [7:0]       mode_two_q;
  logic             wait_q;
  logic [31:0]      rdata_q;
  logic             depth_q;
  logic [2:0]       baud_q;
  logic             rx_en_q;
  logic             tx_en_q;
  logic [1:0]       act_rx_q;
  logic [1:0]       act_tx_q;
  logic [6:0]       wdog_cnt_q;
  logic             wdog_hit_q;
  logic             rx_req_q;
  logic             tx_req_q;
  logic [IRQ_W-1:0] sts_q;
  logic [IRQ_W-1:0] mask_q;
  logic             irq_q;

  // Bus decode: one wait cycle, access takes effect on the ack edge
  wire req      = avs_read | avs_write;
  wire rd_acc   = avs_read & ~wait_q;
  wire wr_acc   = avs_write & ~wait_q;
  wire be0      = avs_byteenable[0];
  wire sel_mode = avs_address == OFS_MODE;
  wire sel_cmd  = avs_address == OFS_CMD;
  wire sel_stat = avs_address == OFS_STAT;
  wire sel_ists = avs_address == OFS_ISTS;
  wire sel_imsk = avs_address == OFS_IMSK;
  wire mode_acc = (rd_acc | wr_acc) & sel_mode;
  wire mode_wr  = wr_acc & sel_mode & be0;
  wire cmd_wr   = wr_acc & sel_cmd & be0;
  wire ists_wr  = wr_acc & sel_ists & be0;
  wire imsk_wr  = wr_acc & sel_imsk & be0;
  wire [7:0] wd = avs_writedata[7:0];
  wire [3:0] cmd_code = wd[CMD_CODE_LSB +: 4];

  // Unknown baud codes are dropped, keeping the last legal group
  wire baud_ok = (wd[2:0] == BAUD_NORMAL) | (wd[2:0] == BAUD_EXT1)
               | (wd[2:0] == BAUD_EXT2);

  // FIFO status from the counts
  wire [CNT_W-1:0] depth_n  = depth_q ? CNT_W'(DEPTH_LARGE) : CNT_W'(DEPTH_SMALL);
  wire [CNT_W-1:0] tx_free  = (tx_count >= depth_n) ? '0 : depth_n - tx_count;
  wire             rx_has_data_flag   = rx_count != '0;
  wire             rx_queue_full_flag = rx_count >= depth_n;
  wire             tx_queue_empty_flag = tx_count == '0;
  wire             tx_has_space_flag  = tx_count < depth_n;

  // New thresholds wait for an idle pair of FIFOs or a FIFO access
  wire apply_lvl = (rx_count == '0 && tx_count == '0) | rx_fifo_access | tx_fifo_access;
  // Receive code is split over the two mode registers
  wire [1:0] prog_rx = {mode_zero_q[MR0_RXUP_BIT], mode_one_q[MR1_RXLO_BIT]};
  wire [1:0] prog_tx = mode_zero_q[MR0_TXTH_LSB +: 2];

  ufml_lvl_if #(.CNT_W(CNT_W)) rx_lv ();
  ufml_lvl_if #(.CNT_W(CNT_W)) tx_lv ();
  assign rx_lv.count = rx_count;
  assign rx_lv.code  = act_rx_q;
  assign rx_lv.deep  = depth_q;
  assign tx_lv.count = tx_free;
  assign tx_lv.code  = act_tx_q;
  assign tx_lv.deep  = depth_q;

  ufml_level_cmp #(.IS_TX(1'b0)) u_rx_cmp (.lv(rx_lv.cmp));
  ufml_level_cmp #(.IS_TX(1'b1)) u_tx_cmp (.lv(tx_lv.cmp));

  // Watchdog counts receiver bit ticks while data sits unread
  wire wdog_en   = mode_zero_q[MR0_WDOG_BIT];
  wire wdog_clr  = ~wdog_en | ~rx_has_data_flag | rx_fifo_access;
  wire wdog_fire = ~wdog_clr & rx_bit_tick & ~wdog_hit_q
                 & (wdog_cnt_q == WDOG_BIT_TIMES - 7'h01);

  wire rx_req_d = rx_lv.hit | wdog_hit_q;
  wire tx_req_d = tx_en_q & tx_lv.hit;

  wire [IRQ_W-1:0] ev;
  assign ev[IRQ_TX]   = tx_req_d & ~tx_req_q;
  assign ev[IRQ_RX]   = rx_req_d & ~rx_req_q;
  assign ev[IRQ_WDOG] = wdog_fire;
  // Set wins over a same-cycle write-one clear
  wire [IRQ_W-1:0] sts_d = (sts_q & ~(ists_wr ? wd[IRQ_W-1:0] : '0)) | ev;

  // Mode pointer: reset or command 1 selects mode-one, access steps it
  always_comb
  begin
    ptr_d = ptr_q;
    if (cmd_wr && cmd_code == CMD_PTR_MR1)
      ptr_d = PTR_MR1;
    else if (cmd_wr && cmd_code == CMD_PTR_MR0)
      ptr_d = PTR_MR0;
    else if (mode_acc)
    begin
      unique case (ptr_q)
        PTR_MR0: ptr_d = PTR_MR1;
        PTR_MR1: ptr_d = PTR_MR2;
        PTR_MR2: ptr_d = PTR_MR2;
        default: ptr_d = PTR_MR1;
      endcase
    end
  end

  wire [7:0] mode_rd = (ptr_q == PTR_MR0) ? mode_zero_q
                     : (ptr_q == PTR_MR1) ? mode_one_q : mode_two_q;
  wire [31:0] stat_rd = {20'h0, wdog_hit_q, ptr_q, tx_req_q, rx_req_q, tx_en_q, rx_en_q,
                         tx_queue_empty_flag, tx_has_space_flag, rx_queue_full_flag,
                         rx_has_data_flag};
  wire [31:0] rd_word = sel_mode ? {24'h0, mode_rd}
                      : sel_stat ? stat_rd
                      : sel_ists ? {29'h0, sts_q}
                      : sel_imsk ? {29'h0, mask_q}
                      : 32'h0;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end
    else
    begin
      wait_q <= wait_q ? ~req : 1'b1;
      if (avs_read && wait_q)
        rdata_q <= rd_word;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ptr_q       <= PTR_MR1;
      mode_zero_q <= MODE_RST;
      mode_one_q  <= MODE_RST;
      mode_two_q  <= MODE_RST;
    end
    else
    begin
      ptr_q <= ptr_d;
      if (mode_wr && ptr_q == PTR_MR0)
        mode_zero_q <= {wd[7:3], baud_ok ? wd[2:0] : mode_zero_q[2:0]};
      if (mode_wr && ptr_q == PTR_MR1)
        mode_one_q <= wd;
      if (mode_wr && ptr_q == PTR_MR2)
        mode_two_q <= wd;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      depth_q <= 1'b0;
      baud_q  <= BAUD_NORMAL;
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end
    else
    begin
      depth_q <= mode_zero_q[MR0_DEPTH_BIT];
      baud_q  <= mode_zero_q[2:0];
      // Disable wins when both bits are written together
      if (cmd_wr)
      begin
        rx_en_q <= ~wd[CMD_RX_DIS_BIT] & (wd[CMD_RX_EN_BIT] | rx_en_q);
        tx_en_q <= ~wd[CMD_TX_DIS_BIT] & (wd[CMD_TX_EN_BIT] | tx_en_q);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      act_rx_q <= 2'h0;
      act_tx_q <= 2'h0;
    end
    else if (apply_lvl)
    begin
      act_rx_q <= prog_rx;
      act_tx_q <= prog_tx;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || wdog_clr)
    begin
      wdog_cnt_q <= 7'h00;
      wdog_hit_q <= 1'b0;
    end
    else if (wdog_fire)
    begin
      wdog_cnt_q <= 7'h00;
      wdog_hit_q <= 1'b1;
    end
    else if (rx_bit_tick && !wdog_hit_q)
      wdog_cnt_q <= wdog_cnt_q + 7'h01;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_req_q <= 1'b0;
      tx_req_q <= 1'b0;
      sts_q    <= IRQ_RST;
      mask_q   <= IRQ_RST;
      irq_q    <= 1'b0;
    end
    else
    begin
      rx_req_q <= rx_req_d;
      tx_req_q <= tx_req_d;
      sts_q    <= sts_d;
      if (imsk_wr)
        mask_q <= wd[IRQ_W-1:0];
      irq_q    <= |(sts_d & (imsk_wr ? wd[IRQ_W-1:0] : mask_q));
    end
  end

  assign avs_readdata         = rdata_q;
  assign avs_waitrequest      = wait_q;
  assign queue_depth_select   = depth_q;
  assign baud_group           = baud_q;
  assign rx_idle_timer_enable = mode_zero_q[MR0_WDOG_BIT];
  assign mode_one             = mode_one_q;
  assign mode_two             = mode_two_q;
  assign rx_enable            = rx_en_q;
  assign tx_enable            = tx_en_q;
  assign rx_irq_req           = rx_req_q;
  assign tx_irq_req           = tx_req_q;
  assign irq                  = irq_q;

  a_tx_reset_req: assert property (@(posedge clk) disable iff (sys_rst)
    (tx_en_q && tx_count == '0) |=> tx_irq_req)
    else $error("empty enabled transmitter did not request");

  a_tx_default_lvl: assert property (@(posedge clk) disable iff (sys_rst)
    (act_tx_q == 2'h0 && tx_count == CNT_W'(1)) |=> !tx_irq_req)
    else $error("code 00 request with one byte loaded");

  a_depth_follows: assert property (@(posedge clk) disable iff (sys_rst)
    (mode_wr && ptr_q == PTR_MR0) |=> ##1 (queue_depth_select == $past(wd[3], 2)))
    else $error("depth select did not follow mode-zero bit 3");

  a_baud_legal: assert property (@(posedge clk) disable iff (sys_rst)
    baud_group == BAUD_NORMAL || baud_group == BAUD_EXT1 || baud_group == BAUD_EXT2)
    else $error("illegal baud group reached output");

  a_rx_small_lvl: assert property (@(posedge clk) disable iff (sys_rst)
    (!depth_q && act_rx_q == 2'h1 && !wdog_hit_q && rx_count == CNT_W'(2)) |=> !rx_irq_req)
    else $error("small receive level 01 fired below 3");

  a_rx_large_lvl: assert property (@(posedge clk) disable iff (sys_rst)
    (depth_q && act_rx_q == 2'h2 && rx_count == CNT_W'(12)) |=> rx_irq_req)
    else $error("large receive level 10 missed at 12");

  a_tx_small_lvl: assert property (@(posedge clk) disable iff (sys_rst)
    (tx_en_q && !depth_q && act_tx_q == 2'h1 && tx_count == CNT_W'(5)) |=> !tx_irq_req)
    else $error("small transmit level 01 fired with 3 free");

  a_tx_large_lvl: assert property (@(posedge clk) disable iff (sys_rst)
    (tx_en_q && depth_q && act_tx_q == 2'h2 && tx_count == CNT_W'(4)) |=> tx_irq_req)
    else $error("large transmit level 10 missed with 12 free");

  a_lvl_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (rx_count != '0 && !rx_fifo_access && !tx_fifo_access) |=> $stable(act_rx_q))
    else $error("receive threshold changed without FIFO access");

  a_ptr_step: assert property (@(posedge clk) disable iff (sys_rst)
    (mode_acc && ptr_q == PTR_MR1) |=> ptr_q == PTR_MR2)
    else $error("pointer did not step to mode-two");

  a_wdog_fire: assert property (@(posedge clk) disable iff (sys_rst)
    wdog_fire |=> wdog_hit_q ##1 rx_irq_req)
    else $error("watchdog expiry did not flag");

  a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
    irq == (|(sts_q & mask_q)))
    else $error("interrupt output disagrees with unmasked status");

endmodule

/* File: tb/ufml_fifo_model.sv */
// Channel FIFO stand-in: occupancy counts, access pulses, bit ticks.
// Assumes the bench steers it through put(); ticks run free.
`timescale 1ns/1ns
module ufml_fifo_model
(
  input  wire logic       clk,
  output logic      [4:0] rx_count,
  output logic      [4:0] tx_count,
  output logic            rx_fifo_access,
  output logic            tx_fifo_access,
  output logic            rx_bit_tick
);
  logic [1:0] div_q;

  // Both queues empty out of reset
  initial
  begin
    rx_count = 5'h00;
    tx_count = 5'h00;
    rx_fifo_access = 1'b0;
    tx_fifo_access = 1'b0;
    rx_bit_tick = 1'b0;
    div_q = 2'h0;
  end

  // One receiver bit time every four clocks
  always @(posedge clk)
  begin
    div_q <= div_q + 2'h1;
    rx_bit_tick <= (div_q == 2'h3);
  end

  // Access pulse lasts one clock, as a real read or write would
  task automatic put(input int rx, input int tx, input bit acc);
    @(posedge clk);
    rx_count <= rx[4:0];
    tx_count <= tx[4:0];
    rx_fifo_access <= acc;
    tx_fifo_access <= acc;
    @(posedge clk);
    rx_fifo_access <= 1'b0;
    tx_fifo_access <= 1'b0;
  endtask
endmodule

/* File: tb/ufml_mode_cfg_tb.sv */
// Self-checking bench for the channel mode and FIFO level logic.
// Assumes the FIFO stand-in drives the FIFO side of the design.
`timescale 1ns/1ns
module ufml_mode_cfg_tb;
  import ufml_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdq;
  logic        wrq, dsel, wde, rxe, txe, rxr, txr, irq;
  logic [2:0]  bg;
  logic [7:0]  m1, m2;
  wire  [4:0]  rxn, txn;
  wire         rxa, txa, tick;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  int          seed = 32'h97cd;
  // Fill and free levels per depth and code
  int          rl [2][4] = '{'{1, 3, 6, 8}, '{1, 8, 12, 16}};
  int          tl [2][4] = '{'{8, 4, 6, 1}, '{16, 8, 12, 1}};

  always #10 clk = ~clk;

  ufml_mode_cfg #(.CNT_W(5)) dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata(rdq), .avs_waitrequest(wrq), .rx_count(rxn), .tx_count(txn),
    .rx_fifo_access(rxa), .tx_fifo_access(txa), .rx_bit_tick(tick),
    .queue_depth_select(dsel), .baud_group(bg), .rx_idle_timer_enable(wde),
    .mode_one(m1), .mode_two(m2), .rx_enable(rxe), .tx_enable(txe),
    .rx_irq_req(rxr), .tx_irq_req(txr), .irq(irq));

  ufml_fifo_model fifo_u (.clk(clk), .rx_count(rxn), .tx_count(txn),
    .rx_fifo_access(rxa), .tx_fifo_access(txa), .rx_bit_tick(tick));

  task automatic wrap_up;
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic bus(input bit we, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wr <= we;
    rd <= !we;
    wd <= {24'h0, d};
    @(posedge clk);
    // No cycle count assumed; the bench timeout ends a hung wait
    while (wrq !== 1'b0)
      @(posedge clk);
    q = rdq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wrt(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic cfg(input int dp, input int rc, input int tc, input logic [2:0] bd,
                     input bit wdg);
    logic [31:0] q;
    wrt(OFS_CMD, {CMD_PTR_MR0, 4'h0});
    wrt(OFS_MODE, {wdg, rc[1], tc[1:0], dp[0], bd});
    wrt(OFS_CMD, {CMD_PTR_MR1, 4'h0});
    wrt(OFS_MODE, {1'b0, rc[0], 6'h00});
    bus(1'b0, OFS_STAT, 8'h00, q);
    chk(q[10:8], 3'b100);
    chk(dsel, dp[0]);
    chk(m1, {1'b0, rc[0], 6'h00});
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end

  initial
  begin
    logic [31:0] q;
    logic [2:0]  bds [3];
    int          r, t, dd, n;
    bds = '{3'h0, 3'h1, 3'h4};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, OFS_STAT, 8'h00, q);
    chk(q, 32'h0000020c);
    bus(1'b0, OFS_MODE, 8'h00, q);
    chk(q, 32'h0);
    bus(1'b0, 5'h14, 8'h00, q);
    chk(q, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      cfg(0, 0, 0, bds[i], 1'b0);
      chk(bg, bds[i]);
    end
    // Illegal group code must not reach the baud logic
    cfg(0, 0, 0, 3'h2, 1'b0);
    chk(bg, 3'h4);
    wrt(OFS_MODE, 8'h5a);
    tk(1);
    chk(m2, 8'h5a);
    bus(1'b0, OFS_MODE, 8'h00, q);
    chk(q, 32'h0000005a);
    wrt(OFS_IMSK, 8'h01);
    chk(txr, 1'b0);
    wrt(OFS_CMD, 8'h04);
    tk(3);
    chk(txr, 1'b1);
    chk(irq, 1'b1);
    chk(txe, 1'b1);
    fifo_u.put(0, 1, 1'b1);
    tk(2);
    chk(txr, 1'b0);
    fifo_u.put(0, 0, 1'b1);
    tk(3);
    chk(txr, 1'b1);
    wrt(OFS_IMSK, 8'h00);
    tk(2);
    chk(irq, 1'b0);
    wrt(OFS_IMSK, 8'h01);
    wrt(OFS_ISTS, 8'h01);
    tk(2);
    chk(irq, 1'b0);
    bus(1'b0, OFS_ISTS, 8'h00, q);
    chk(q, 32'h0);
    wrt(OFS_CMD, 8'h01);
    tk(1);
    chk(rxe, 1'b1);
    // Enable and disable together: disable wins
    wrt(OFS_CMD, 8'h03);
    tk(1);
    chk(rxe, 1'b0);
    chk(txe, 1'b1);
    // Levels at threshold minus one, at threshold, and random
    for (int d = 0; d < 2; d++)
      for (int rc = 0; rc < 4; rc++)
        for (int tc = 0; tc < 4; tc++)
        begin
          dd = 8 * (d + 1);
          cfg(d, rc, tc, 3'h0, 1'b0);
          for (int k = 0; k < 3; k++)
          begin
            r = (k == 2) ? $unsigned($random(seed)) % (dd + 1) : rl[d][rc] - 1 + k;
            t = (k == 2) ? $unsigned($random(seed)) % (dd + 1) : dd - tl[d][tc] + 1 - k;
            fifo_u.put(r, t, 1'b0);
            tk(3);
            chk(rxr, r >= rl[d][rc]);
            chk(txr, dd - t >= tl[d][tc]);
          end
          fifo_u.put(0, 0, 1'b0);
          tk(2);
        end
    cfg(0, 0, 0, 3'h0, 1'b0);
    fifo_u.put(3, 0, 1'b0);
    tk(3);
    chk(rxr, 1'b1);
    cfg(0, 3, 0, 3'h0, 1'b0);
    tk(2);
    chk(rxr, 1'b1);
    fifo_u.put(3, 0, 1'b1);
    tk(3);
    chk(rxr, 1'b0);
    fifo_u.put(0, 0, 1'b0);
    cfg(0, 3, 0, 3'h0, 1'b1);
    chk(wde, 1'b1);
    fifo_u.put(1, 0, 1'b0);
    n = 0;
    while (rxr !== 1'b1 && n < 400)
    begin
      n++;
      @(posedge clk);
    end
    chk(n >= 248 && n <= 264, 1'b1);
    fifo_u.put(1, 0, 1'b1);
    tk(3);
    chk(rxr, 1'b0);
    wrap_up();
  end
endmodule
